/* File: rtl/fws_bus_cycle.sv */
// one asynchronous flash read or write cycle on the parallel pins
`timescale 1ns/1ps
`include "fws_params.svh"
module fws_bus_cycle
	import fws_pkg::*;
#(
	parameter int T_SETUP = `FWS_T_SETUP_CYC,
	parameter int T_STROBE = `FWS_T_STROBE_CYC,
	parameter int T_HOLD = `FWS_T_HOLD_CYC
)(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// request
	input wire logic start,
	input wire fws_req_t req,
	output logic busy,
	output logic done,
	output logic [`FWS_DATA_W-1:0] rdata,
	// flash pins
	output fws_pins_t pins,
	input wire logic [`FWS_DATA_W-1:0] dq_in
);

	typedef enum logic [4:0] {
		FWS_BC_IDLE = 5'h01,
		FWS_BC_SETUP = 5'h02,
		FWS_BC_STROBE = 5'h04,
		FWS_BC_SAMPLE = 5'h08,
		FWS_BC_HOLD = 5'h10
	} fws_bc_state_t;

	fws_bc_state_t state;
	fws_req_t cur;
	logic [7:0] cnt;
	logic [`FWS_DATA_W-1:0] dq_s1;
	logic [`FWS_DATA_W-1:0] dq_s2;
	logic [`FWS_DATA_W-1:0] dq_s3;
	logic strobe;

	// ----------------------------------------
	// data input synchroniser
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dq_s1 <= '0;
			dq_s2 <= '0;
			dq_s3 <= '0;
		end
		else
		begin
			dq_s1 <= dq_in;
			dq_s2 <= dq_s1;
			dq_s3 <= dq_s2;
		end
	end

	// ----------------------------------------
	// cycle sequencing
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= FWS_BC_IDLE;
			cur <= '0;
			cnt <= 8'h00;
			done <= 1'b0;
			rdata <= '0;
		end
		else
		begin
			done <= 1'b0;
			unique case (state)
				FWS_BC_IDLE:
				begin
					if (start)
					begin
						cur <= req;
						cnt <= 8'(T_SETUP - 1);
						state <= FWS_BC_SETUP;
					end
				end
				FWS_BC_SETUP:
				begin
					cnt <= cnt - 8'h01;
					if (cnt == 8'h00)
					begin
						cnt <= 8'(T_STROBE - 1);
						state <= FWS_BC_STROBE;
					end
				end
				FWS_BC_STROBE:
				begin
					cnt <= cnt - 8'h01;
					if (cnt == 8'h00)
					begin
						cnt <= 8'(T_HOLD - 1);
						state <= cur.write ? FWS_BC_HOLD : FWS_BC_SAMPLE;
					end
				end
				FWS_BC_SAMPLE:
				begin
					// status bits can move during the strobe; wait for two equal samples
					if (dq_s2 == dq_s3)
					begin
						rdata <= dq_s3;
						state <= FWS_BC_HOLD;
					end
				end
				FWS_BC_HOLD:
				begin
					cnt <= cnt - 8'h01;
					if (cnt == 8'h00)
					begin
						done <= 1'b1;
						state <= FWS_BC_IDLE;
					end
				end
				default:
				begin
					state <= FWS_BC_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// pin decode
	// ----------------------------------------
	assign busy = !state[0];
	assign strobe = (state == FWS_BC_STROBE) || (state == FWS_BC_SAMPLE);

	always_comb
	begin
		pins.addr = cur.addr;
		pins.dq = cur.data;
		pins.dq_oe = cur.write && busy;
		pins.we_n = !(cur.write && (state == FWS_BC_STROBE));
		if (!cur.write && cur.use_ce)
		begin
			// chip enable frames the read, output enable held low [R16]
			pins.ce_n = !strobe;
			pins.oe_n = !busy;
		end
		else
		begin
			pins.ce_n = !busy;
			pins.oe_n = cur.write || !strobe;
		end
	end

endmodule : fws_bus_cycle

/* File: rtl/fws_host.sv */
// host controller: issues flash program/erase commands and runs status polling
`timescale 1ns/1ps
`include "fws_params.svh"
module fws_host
	import fws_pkg::*;
#(
	parameter int RB_SETTLE = `FWS_RB_SETTLE_CYC
)(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic [`FWS_APB_AW-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// flash pins
	output logic flash_ce_n,
	output logic flash_oe_n,
	output logic flash_we_n,
	output logic [`FWS_ADDR_W-1:0] flash_addr,
	output logic [`FWS_DATA_W-1:0] flash_dq_out,
	output logic flash_dq_oe,
	input wire logic [`FWS_DATA_W-1:0] flash_dq_in,
	input wire logic ready_busy_pin
);

	typedef enum logic [7:0] {
		FWS_S_IDLE = 8'h01,
		FWS_S_CMD = 8'h02,
		FWS_S_CMDW = 8'h04,
		FWS_S_RD = 8'h08,
		FWS_S_RDW = 8'h10,
		FWS_S_EVAL = 8'h20,
		FWS_S_RST = 8'h40,
		FWS_S_RBW = 8'h80
	} fws_state_t;

	fws_state_t state;
	fws_op_t op;
	fws_meth_t meth;
	logic use_ce;
	logic [`FWS_ADDR_W-1:0] op_addr;
	logic [`FWS_DATA_W-1:0] op_data;
	logic [`FWS_DATA_W-1:0] first_rd;
	logic [`FWS_DATA_W-1:0] last_rd;
	logic [`FWS_DATA_W-1:0] result;
	logic [2:0] step;
	logic [1:0] rd_cnt;
	logic recheck;
	logic confirm;
	logic st_done;
	logic st_fail;
	logic st_sector;
	logic st_tlimit;
	logic [15:0] settle;
	logic rb_s1;
	logic rb_s2;
	logic rb_s3;
	logic rb_ready;
	logic apb_setup;
	logic apb_wr;
	logic mapped;
	logic start_req;
	logic busy;
	logic bc_start;
	logic bc_busy;
	logic bc_done;
	logic [`FWS_DATA_W-1:0] bc_rdata;
	fws_req_t bc_req;
	fws_pins_t pins;
	logic polled;
	logic exp7;
	logic toggling;

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	assign apb_setup = psel && !penable;
	assign pready = 1'b1;
	assign mapped = (paddr == `FWS_REG_CTRL) || (paddr == `FWS_REG_ADDR) || (paddr == `FWS_REG_DATA)
		|| (paddr == `FWS_REG_STATUS) || (paddr == `FWS_REG_RDATA);
	assign pslverr = psel && penable && !mapped;
	assign apb_wr = psel && penable && pwrite && mapped;
	assign busy = (state != FWS_S_IDLE);
	// a start while busy is dropped
	assign start_req = apb_wr && (paddr == `FWS_REG_CTRL) && pwdata[`FWS_CTRL_START] && !busy;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h00000000;
		end
		else if (apb_setup && !pwrite)
		begin
			prdata <= 32'h00000000;
			case (paddr)
				`FWS_REG_CTRL:
				begin
					prdata[`FWS_CTRL_OP_MSB:`FWS_CTRL_OP_LSB] <= op;
					prdata[`FWS_CTRL_METH_MSB:`FWS_CTRL_METH_LSB] <= meth;
					prdata[`FWS_CTRL_USE_CE] <= use_ce;
				end
				`FWS_REG_ADDR: prdata[`FWS_ADDR_W-1:0] <= op_addr;
				`FWS_REG_DATA: prdata[`FWS_DATA_W-1:0] <= op_data;
				`FWS_REG_STATUS:
				begin
					prdata[`FWS_ST_BUSY] <= busy;
					prdata[`FWS_ST_DONE] <= st_done;
					prdata[`FWS_ST_FAIL] <= st_fail;
					prdata[`FWS_ST_READY] <= rb_ready;
					prdata[`FWS_ST_SECTOR] <= st_sector;
					prdata[`FWS_ST_TLIMIT] <= st_tlimit;
				end
				`FWS_REG_RDATA: prdata[`FWS_DATA_W-1:0] <= result;
				default: prdata <= 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------
	// software registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			op <= FWS_OP_NONE;
			meth <= FWS_M_TOGGLE;
			use_ce <= 1'b0;
			op_addr <= '0;
			op_data <= '0;
		end
		else if (apb_wr && !busy)
		begin
			// settings are frozen while an operation runs
			if (paddr == `FWS_REG_CTRL)
			begin
				op <= fws_op_t'(pwdata[`FWS_CTRL_OP_MSB:`FWS_CTRL_OP_LSB]);
				meth <= fws_meth_t'(pwdata[`FWS_CTRL_METH_MSB:`FWS_CTRL_METH_LSB]);
				use_ce <= pwdata[`FWS_CTRL_USE_CE];
			end
			if (paddr == `FWS_REG_ADDR)
				op_addr <= pwdata[`FWS_ADDR_W-1:0];
			if (paddr == `FWS_REG_DATA)
				op_data <= pwdata[`FWS_DATA_W-1:0];
		end
	end

	// ----------------------------------------
	// ready/busy pin synchroniser
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rb_s1 <= 1'b0;
			rb_s2 <= 1'b0;
			rb_s3 <= 1'b0;
			rb_ready <= 1'b0;
		end
		else
		begin
			rb_s1 <= ready_busy_pin;
			rb_s2 <= rb_s1;
			rb_s3 <= rb_s2;
			if (rb_s2 == rb_s3)
				rb_ready <= rb_s3;
		end
	end

	// ----------------------------------------
	// command table and bus requests
	// ----------------------------------------
	function automatic logic [`FWS_ADDR_W+`FWS_DATA_W-1:0] cmd_step(input fws_op_t o, input logic [2:0] s,
		input logic [`FWS_ADDR_W-1:0] a, input logic [`FWS_DATA_W-1:0] d);
		logic [`FWS_DATA_W-1:0] c3;
		c3 = (o == FWS_OP_PROGRAM) ? `FWS_CMD_PROGRAM : `FWS_CMD_ERASE_SETUP;
		if (o == FWS_OP_RESET)
			return {`FWS_ANY_ADDR, `FWS_CMD_RESET};
		if (o == FWS_OP_SUSPEND)
			return {`FWS_ANY_ADDR, `FWS_CMD_SUSPEND};
		if (o == FWS_OP_RESUME)
			return {`FWS_ANY_ADDR, `FWS_CMD_RESUME};
		case (s)
			3'h0, 3'h3: cmd_step = (o == FWS_OP_PROGRAM && s == 3'h3) ? {a, d} : {`FWS_UNLOCK_A1, `FWS_UNLOCK_D1};
			3'h1, 3'h4: cmd_step = {`FWS_UNLOCK_A2, `FWS_UNLOCK_D2};
			3'h2: cmd_step = {`FWS_UNLOCK_A1, c3};
			default: cmd_step = (o == FWS_OP_SECTOR_ERASE) ? {a, `FWS_CMD_SECTOR_ERASE}
				: {`FWS_UNLOCK_A1, `FWS_CMD_CHIP_ERASE};
		endcase
	endfunction : cmd_step

	assign polled = (op == FWS_OP_PROGRAM) || (op == FWS_OP_SECTOR_ERASE) || (op == FWS_OP_CHIP_ERASE);
	// program expects its own bit 7, erase expects one [R1] [R2] [R4]
	assign exp7 = (op == FWS_OP_PROGRAM) ? op_data[`FWS_BIT_POLL] : 1'b1;
	// any change between two reads counts, however far apart [R12] [R22]
	assign toggling = first_rd[`FWS_BIT_TOGGLE_ONE] ^ last_rd[`FWS_BIT_TOGGLE_ONE];
	// reset state spans the whole write; launch it once, not again on its done cycle [R21]
	assign bc_start = (state == FWS_S_CMD) || (state == FWS_S_RD)
		|| ((state == FWS_S_RST) && !bc_busy && !bc_done);

	always_comb
	begin
		bc_req.use_ce = use_ce;
		bc_req.write = (state != FWS_S_RD);
		{bc_req.addr, bc_req.data} = cmd_step(op, step, op_addr, op_data);
		if (state == FWS_S_RD)
			{bc_req.addr, bc_req.data} = {op_addr, op_data}; // poll at target address [R5]
		else if (state == FWS_S_RST)
			{bc_req.addr, bc_req.data} = {`FWS_ANY_ADDR, `FWS_CMD_RESET}; // [R21]
	end

	fws_bus_cycle u_cycle (
		.pclk(pclk),
		.presetn(presetn),
		.start(bc_start),
		.req(bc_req),
		.busy(bc_busy),
		.done(bc_done),
		.rdata(bc_rdata),
		.pins(pins),
		.dq_in(flash_dq_in)
	);

	assign flash_ce_n = pins.ce_n;
	assign flash_oe_n = pins.oe_n;
	assign flash_we_n = pins.we_n;
	assign flash_addr = pins.addr;
	assign flash_dq_out = pins.dq;
	assign flash_dq_oe = pins.dq_oe;

	// ----------------------------------------
	// operation sequencer
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= FWS_S_IDLE;
			step <= 3'h0;
			rd_cnt <= 2'h0;
			recheck <= 1'b0;
			confirm <= 1'b0;
			first_rd <= '0;
			last_rd <= '0;
			result <= '0;
			settle <= 16'h0000;
			st_done <= 1'b0;
			st_fail <= 1'b0;
			st_sector <= 1'b0;
			st_tlimit <= 1'b0;
		end
		else
		begin
			if (apb_wr && paddr == `FWS_REG_STATUS)
			begin
				if (pwdata[`FWS_ST_DONE])
					st_done <= 1'b0;
				if (pwdata[`FWS_ST_FAIL])
					st_fail <= 1'b0;
			end
			unique case (state)
				FWS_S_IDLE:
				begin
					if (start_req)
					begin
						step <= 3'h0;
						rd_cnt <= 2'h0;
						recheck <= 1'b0;
						confirm <= 1'b0;
						st_done <= 1'b0;
						st_fail <= 1'b0;
						st_tlimit <= 1'b0;
						state <= (fws_op_t'(pwdata[`FWS_CTRL_OP_MSB:`FWS_CTRL_OP_LSB]) == FWS_OP_READ)
							? FWS_S_RD : FWS_S_CMD;
					end
				end
				FWS_S_CMD: state <= FWS_S_CMDW;
				FWS_S_CMDW:
				begin
					if (bc_done)
					begin
						step <= step + 3'h1;
						state <= FWS_S_CMD;
						if (step == ((op == FWS_OP_PROGRAM) ? `FWS_LAST_PROGRAM
							: polled ? `FWS_LAST_ERASE : `FWS_LAST_SINGLE))
						begin
							// last write strobe has risen, status is now valid [R9]
							settle <= 16'(RB_SETTLE);
							state <= !polled ? FWS_S_IDLE : (meth == FWS_M_READY) ? FWS_S_RBW : FWS_S_RD;
							st_done <= !polled;
						end
					end
				end
				FWS_S_RD: state <= FWS_S_RDW;
				FWS_S_RDW:
				begin
					if (bc_done)
					begin
						if (rd_cnt == 2'h0)
							first_rd <= bc_rdata;
						last_rd <= bc_rdata;
						rd_cnt <= rd_cnt + 2'h1;
						state <= FWS_S_EVAL;
					end
				end
				FWS_S_EVAL:
				begin
					if (!polled)
					begin
						result <= last_rd;
						st_done <= 1'b1;
						state <= FWS_S_IDLE;
					end
					else if (meth == FWS_M_POLL)
					begin
						if (confirm)
						begin
							// bit 7 settled on the previous read; this one holds data [R8]
							result <= last_rd;
							st_done <= 1'b1;
							state <= FWS_S_IDLE;
						end
						else if (last_rd[`FWS_BIT_POLL] == exp7)
						begin
							confirm <= 1'b1; // [R8]
							state <= FWS_S_RD;
						end
						else if (recheck)
						begin
							st_tlimit <= 1'b1;
							state <= FWS_S_RST; // [R18]
						end
						else
						begin
							recheck <= last_rd[`FWS_BIT_TIME_LIMIT]; // [R20]
							state <= FWS_S_RD;
						end
					end
					else if (rd_cnt == 2'h1)
					begin
						state <= FWS_S_RD; // second read of the pair [R17]
					end
					else if (!toggling)
					begin
						result <= last_rd;
						st_done <= 1'b1;
						state <= FWS_S_IDLE; // [R17]
					end
					else if (recheck)
					begin
						st_tlimit <= 1'b1;
						state <= FWS_S_RST; // still toggling after time limit [R18]
					end
					else
					begin
						st_sector <= first_rd[`FWS_BIT_TOGGLE_TWO] ^ last_rd[`FWS_BIT_TOGGLE_TWO]; // [R15]
						recheck <= last_rd[`FWS_BIT_TIME_LIMIT]; // [R18] [R20]
						rd_cnt <= 2'h0; // fresh double read each round [R19]
						state <= FWS_S_RD;
					end
				end
				FWS_S_RST:
				begin
					if (bc_done)
					begin
						st_fail <= 1'b1; // [R21]
						st_done <= 1'b1;
						state <= FWS_S_IDLE;
					end
				end
				FWS_S_RBW:
				begin
					// pin is slow to fall after the last strobe, so wait before trusting it
					if (settle != 16'h0000)
						settle <= settle - 16'h0001;
					else if (rb_ready)
					begin
						st_done <= 1'b1; // released high means ready [R11]
						state <= FWS_S_IDLE;
					end
				end
				default: state <= FWS_S_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_strobe_excl: assert property (@(posedge pclk) disable iff (!presetn) !(!flash_oe_n && !flash_we_n))
		else $error("read and write strobes low together");
	a_poll_address: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
		(state == FWS_S_RDW && bc_busy && !flash_oe_n) |-> (flash_addr == op_addr))
		else $error("status read not at target address");
	a_ce_read: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
		(state == FWS_S_RDW && bc_busy && use_ce) |-> (!flash_oe_n && !flash_dq_oe))
		else $error("chip enable controlled read lost output enable");
	a_double_read: assert property (@(posedge pclk) disable iff (!presetn) // [R17]
		(state == FWS_S_EVAL && polled && meth != FWS_M_POLL && rd_cnt == 2'h1) |=> (state == FWS_S_RD) ##1 (state == FWS_S_RDW))
		else $error("toggle judged on a single read");
	a_confirm_read: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
		(state == FWS_S_EVAL && polled && meth == FWS_M_POLL && !confirm) |=> (state != FWS_S_IDLE))
		else $error("data taken on the read where bit 7 settled");
	a_limit_retest: assert property (@(posedge pclk) disable iff (!presetn) // [R18]
		(state == FWS_S_EVAL && polled && meth != FWS_M_POLL && rd_cnt == 2'h2 && toggling && !recheck)
		|=> (state == FWS_S_RD && rd_cnt == 2'h0)) // [R19]
		else $error("toggle round not restarted");
	a_fail_reset: assert property (@(posedge pclk) disable iff (!presetn) // [R21]
		(state == FWS_S_EVAL && $past(state) == FWS_S_RDW && recheck && $stable(recheck)) ##1 (state == FWS_S_RST)
		|-> (bc_req.write && bc_req.data == `FWS_CMD_RESET) ##1 (state == FWS_S_RST && !st_fail))
		else $error("failure not followed by reset command");
	a_single_reset: assert property (@(posedge pclk) disable iff (!presetn) // [R21]
		(state == FWS_S_RST && bc_done) |=> !bc_busy)
		else $error("reset command written more than once");
	a_start_taken: assert property (@(posedge pclk) disable iff (!presetn)
		start_req |=> (state == FWS_S_CMD || state == FWS_S_RD) && !st_done && !st_fail)
		else $error("start not taken");

endmodule : fws_host

/* File: rtl/fws_params.svh */
// constants for the flash write-status host controller
// Contract
// R1: program polls complement of bit 7, then true
// R2: same polling for program during erase suspend
// R3: protected program shows busy about 2 us
// R4: erase polls bit 7 low, high when done
// R5: host polls at program or erasing address
// R6: all-protected erase shows busy about 100 us
// R7: erase skips protected sectors, erases the rest
// R8: data valid only on read after bit 7
// R9: status valid after last write strobe rises
// R10: ready/busy pin is open drain, wired-or
// R11: ready/busy low while busy, high when ready
// R12: toggle bit one flips each read while busy
// R13: toggle bit one flips during erase timeout
// R14: toggle stops in suspend, resumes for program
// R15: toggle bit two flips in erasing sectors
// R16: toggle read counts with oe or ce control
// R17: host starts with two reads and compares
// R18: on time limit bit, retest, then fail
// R19: resumed monitoring restarts from double read
// R20: time limit bit high on pulse-count overrun
// R21: after failure write reset command f0 once
// R22: toggle bits invert per read, not time
`ifndef FWS_PARAMS_SVH
`define FWS_PARAMS_SVH

`define FWS_ADDR_W 20
`define FWS_DATA_W 16
`define FWS_APB_AW 8

// ----------------------------------------
// timing
// ----------------------------------------
`define FWS_CLK_PERIOD_NS 5
`define FWS_T_SETUP_NS 10
`define FWS_T_STROBE_NS 70
`define FWS_T_HOLD_NS 30
`define FWS_RB_SETTLE_NS 500
`define FWS_NS_TO_CYC(ns) (((ns) + `FWS_CLK_PERIOD_NS - 1) / `FWS_CLK_PERIOD_NS)
`define FWS_T_SETUP_CYC `FWS_NS_TO_CYC(`FWS_T_SETUP_NS)
`define FWS_T_STROBE_CYC `FWS_NS_TO_CYC(`FWS_T_STROBE_NS)
`define FWS_T_HOLD_CYC `FWS_NS_TO_CYC(`FWS_T_HOLD_NS)
`define FWS_RB_SETTLE_CYC `FWS_NS_TO_CYC(`FWS_RB_SETTLE_NS)

// ----------------------------------------
// register map and fields
// ----------------------------------------
`define FWS_REG_CTRL 8'h00
`define FWS_REG_ADDR 8'h04
`define FWS_REG_DATA 8'h08
`define FWS_REG_STATUS 8'h0c
`define FWS_REG_RDATA 8'h10
`define FWS_CTRL_START 0
`define FWS_CTRL_OP_LSB 1
`define FWS_CTRL_OP_MSB 3
`define FWS_CTRL_METH_LSB 4
`define FWS_CTRL_METH_MSB 5
`define FWS_CTRL_USE_CE 6
`define FWS_ST_BUSY 0
`define FWS_ST_DONE 1
`define FWS_ST_FAIL 2
`define FWS_ST_READY 3
`define FWS_ST_SECTOR 4
`define FWS_ST_TLIMIT 5

// ----------------------------------------
// flash command cycles and status bits
// ----------------------------------------
`define FWS_UNLOCK_A1 20'h00555
`define FWS_UNLOCK_A2 20'h002aa
`define FWS_UNLOCK_D1 16'h00aa
`define FWS_UNLOCK_D2 16'h0055
`define FWS_CMD_PROGRAM 16'h00a0
`define FWS_CMD_ERASE_SETUP 16'h0080
`define FWS_CMD_CHIP_ERASE 16'h0010
`define FWS_CMD_SECTOR_ERASE 16'h0030
`define FWS_CMD_RESET 16'h00f0
`define FWS_CMD_SUSPEND 16'h00b0
`define FWS_CMD_RESUME 16'h0030
`define FWS_ANY_ADDR 20'h00000
`define FWS_LAST_PROGRAM 3'h3
`define FWS_LAST_ERASE 3'h5
`define FWS_LAST_SINGLE 3'h0
`define FWS_BIT_POLL 7
`define FWS_BIT_TOGGLE_ONE 6
`define FWS_BIT_TIME_LIMIT 5
`define FWS_BIT_TOGGLE_TWO 2

`endif

/* File: rtl/fws_pkg.sv */
// types shared by the flash write-status host controller
`include "fws_params.svh"
package fws_pkg;

	typedef enum logic [2:0] {
		FWS_OP_NONE = 3'h0,
		FWS_OP_PROGRAM = 3'h1,
		FWS_OP_SECTOR_ERASE = 3'h2,
		FWS_OP_CHIP_ERASE = 3'h3,
		FWS_OP_RESET = 3'h4,
		FWS_OP_READ = 3'h5,
		FWS_OP_SUSPEND = 3'h6,
		FWS_OP_RESUME = 3'h7
	} fws_op_t;

	typedef enum logic [1:0] {
		FWS_M_TOGGLE = 2'h0,
		FWS_M_POLL = 2'h1,
		FWS_M_READY = 2'h2,
		FWS_M_SPARE = 2'h3
	} fws_meth_t;

	typedef struct packed {
		logic write;
		logic use_ce;
		logic [`FWS_ADDR_W-1:0] addr;
		logic [`FWS_DATA_W-1:0] data;
	} fws_req_t;

	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic [`FWS_ADDR_W-1:0] addr;
		logic [`FWS_DATA_W-1:0] dq;
		logic dq_oe;
	} fws_pins_t;

endpackage : fws_pkg

/* File: sim/fws_flash_model.sv */
// behavioural flash device answering program, erase and status reads
`timescale 1ns/1ps
module fws_flash_model #(
	parameter int PROG_NS = 1500,
	parameter int ERASE_NS = 4000,
	parameter logic [7:0] PROT = 8'h0f
)(
	// strobes and buses
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic [19:0] addr,
	input wire logic [15:0] din,
	// fault injection
	input wire logic stuck,
	// outputs
	output logic [15:0] dq,
	output logic rb_low
);
	logic [15:0] mem [int];
	logic [15:0] last, pd, val;
	logic [19:0] pa;
	logic [7:0] esec;
	logic pbusy, ebusy, susp, chip, t1, t2, tlim;
	int step, rem;
	event go_p, go_e;
	wire rd = !ce_n && !oe_n && we_n;
	wire wr = !ce_n && !we_n;
	wire in_e = ebusy && (chip || addr[19:12] == esec);
	function automatic logic [15:0] arr(input logic [19:0] a);
		return mem.exists(a) ? mem[a] : 16'hffff;
	endfunction : arr
	initial
	begin
		{pbusy, ebusy, susp, chip, t1, t2, tlim} = 7'h00;
		step = 0;
		last = 16'h0000;
		mem[20'h0f000] = 16'h5a5a;
	end
	always_comb
	begin
		val = arr(addr);
		if (pbusy)
			val = {8'h00, ~pd[7], t1, tlim, 5'h00};
		else if (ebusy && !susp)
			val = {8'h00, 1'b0, t1, tlim, 2'h0, t2, 2'h0};
		else if (susp && in_e)
			val = {8'h00, 1'b1, t1, 3'h0, t2, 2'h0};
	end
	// released bus shows inverse of last value, never a held copy
	assign dq = rd ? val : ~last;
	assign rb_low = pbusy || (ebusy && !susp);
	always @(negedge rd)
	begin
		last <= val;
		if (pbusy || (ebusy && !susp))
			t1 <= ~t1;
		if (in_e)
			t2 <= ~t2;
	end
	always @(negedge wr)
	begin
		if (din[7:0] == 8'hf0)
		begin
			{pbusy, ebusy, susp, tlim} = 4'h0;
			step = 0;
		end
		else if (din[7:0] == 8'hb0 && ebusy)
			susp = 1'b1;
		else if (din[7:0] == 8'h30 && susp && step == 0)
			susp = 1'b0;
		else
			case (step)
				0: step = (addr[10:0] == 11'h555 && din[7:0] == 8'haa) ? 1 : 0;
				1: step = (addr[10:0] == 11'h2aa && din[7:0] == 8'h55) ? 2 : 0;
				2: step = din[7:0] == 8'ha0 ? 3 : din[7:0] == 8'h80 ? 4 : 0;
				3:
				begin
					pa = addr;
					pd = din;
					step = 0;
					-> go_p;
				end
				4: step = din[7:0] == 8'haa ? 5 : 0;
				5: step = din[7:0] == 8'h55 ? 6 : 0;
				6:
				begin
					chip = din[7:0] == 8'h10;
					esec = addr[19:12];
					step = 0;
					if (chip || din[7:0] == 8'h30)
						-> go_e;
				end
				default: step = 0;
			endcase
	end
	always @(go_p)
	begin
		pbusy = 1'b1;
		if (stuck)
		begin
			#1000;
			tlim = 1'b1;
		end
		else
		begin
			#((pa[19:12] == PROT) ? 2000 : PROG_NS);
			if (pa[19:12] != PROT)
				mem[pa] = arr(pa) & pd;
			pbusy = 1'b0;
		end
	end
	always @(go_e)
	begin
		ebusy = 1'b1;
		rem = (!chip && esec == PROT) ? 100000 : ERASE_NS;
		// suspend freezes the remaining erase time
		while (rem > 0 && ebusy)
		begin
			#100;
			if (!susp)
				rem -= 100;
		end
		if (ebusy)
			foreach (mem[a])
				if (a[19:12] != PROT && (chip || a[19:12] == esec))
					mem[a] = 16'hffff;
		ebusy = 1'b0;
	end
endmodule : fws_flash_model

/* File: sim/testbench.sv */
// self-checking bench for the flash write-status host controller
`timescale 1ns/1ps
`include "fws_params.svh"
module testbench
	import fws_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, err, stuck;
	logic pready, pslverr, ce_n, oe_n, we_n, dq_oe, rb_low;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [19:0] fa;
	logic [15:0] dq_out, m_dq;
	int n_fail, comparisons;
	wire logic [15:0] dq_in = dq_oe ? dq_out : m_dq;
	// pull-up on the open-drain line
	wire logic ready_busy_pin = !rb_low;

	fws_host #(.RB_SETTLE(4)) fws_host_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_addr(fa),
		.flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(dq_in), .ready_busy_pin(ready_busy_pin));
	fws_flash_model fws_flash_model_i (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(fa), .din(dq_in),
		.stuck(stuck), .dq(m_dq), .rb_low(rb_low));

	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e)
		begin
			n_fail++;
			$display("mismatch t=%0t seen %h exp %h", $time, s, e);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// one controller operation, then status and read-back checks
	task automatic run(input fws_op_t o, input fws_meth_t m, input logic ce, input logic [19:0] a,
		input logic [15:0] d, input logic [31:0] st, input logic [15:0] rx);
		int n;
		apb(1'b1, `FWS_REG_ADDR, {12'h000, a});
		apb(1'b1, `FWS_REG_DATA, {16'h0000, d});
		apb(1'b1, `FWS_REG_CTRL, {25'h0, ce, m, o, 1'b1});
		n = 0;
		do
		begin
			apb(1'b0, `FWS_REG_STATUS, 32'h0);
			n++;
		end
		while (q[1:0] !== 2'b10 && n < 5000);
		chk(q & 32'h27, st);
		if (m != FWS_M_READY && st == 32'h2)
		begin
			apb(1'b0, `FWS_REG_RDATA, 32'h0);
			chk(q, {16'h0000, rx});
		end
	endtask : run

	task automatic summarize;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize

	initial
	begin
		#300000;
		n_fail++;
		summarize();
	end

	initial
	begin
		{presetn, psel, penable, pwrite, stuck} = 5'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		n_fail = 0;
		comparisons = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
		apb(1'b0, `FWS_REG_STATUS, 32'h0);
		chk(q, 32'h8);
		apb(1'b0, 8'h20, 32'h0);
		chk({err, q[30:0]}, 32'h80000000);
		run(FWS_OP_PROGRAM, FWS_M_TOGGLE, 1'b0, 20'h01000, 16'h1234, 32'h2, 16'h1234);
		run(FWS_OP_PROGRAM, FWS_M_POLL, 1'b1, 20'h01001, 16'h00a5, 32'h2, 16'h00a5);
		run(FWS_OP_PROGRAM, FWS_M_TOGGLE, 1'b0, 20'h0f000, 16'h0000, 32'h2, 16'h5a5a);
		run(FWS_OP_SECTOR_ERASE, FWS_M_POLL, 1'b0, 20'h01000, 16'h0000, 32'h2, 16'hffff);
		run(FWS_OP_READ, FWS_M_TOGGLE, 1'b0, 20'h01000, 16'h0000, 32'h2, 16'hffff);
		run(FWS_OP_PROGRAM, FWS_M_READY, 1'b0, 20'h02000, 16'h0f0f, 32'h2, 16'h0000);
		run(FWS_OP_READ, FWS_M_TOGGLE, 1'b1, 20'h02000, 16'h0000, 32'h2, 16'h0f0f);
		run(FWS_OP_CHIP_ERASE, FWS_M_TOGGLE, 1'b0, 20'h02000, 16'h0000, 32'h2, 16'hffff);
		apb(1'b0, `FWS_REG_STATUS, 32'h0);
		chk(q & 32'h10, 32'h10);
		run(FWS_OP_READ, FWS_M_TOGGLE, 1'b0, 20'h0f000, 16'h0000, 32'h2, 16'h5a5a);
		stuck = 1'b1;
		run(FWS_OP_PROGRAM, FWS_M_TOGGLE, 1'b0, 20'h03000, 16'h0000, 32'h26, 16'h0000);
		stuck = 1'b0;
		apb(1'b1, `FWS_REG_STATUS, 32'h6);
		apb(1'b0, `FWS_REG_STATUS, 32'h0);
		chk(q & 32'h6, 32'h0);
		run(FWS_OP_READ, FWS_M_TOGGLE, 1'b0, 20'h03000, 16'h0000, 32'h2, 16'hffff);
		run(FWS_OP_SUSPEND, FWS_M_READY, 1'b0, 20'h00000, 16'h0000, 32'h2, 16'h0000);
		run(FWS_OP_RESUME, FWS_M_READY, 1'b0, 20'h00000, 16'h0000, 32'h2, 16'h0000);
		run(FWS_OP_RESET, FWS_M_READY, 1'b0, 20'h00000, 16'h0000, 32'h2, 16'h0000);
		run(FWS_OP_READ, FWS_M_TOGGLE, 1'b0, 20'h0f000, 16'h0000, 32'h2, 16'h5a5a);
		summarize();
	end
endmodule : testbench
